// ### src/fimf_pkg.sv
// Shared constants and types for the interleave, map and framing stage.
// Assumes a single clock domain; all users reference names with fimf_pkg::.
package fimf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Interleaver buffer geometry.
  localparam int BLK_DIM = 16;
  localparam int BLK_BITS = 256;
  localparam int BLK_COLS = 8;
  localparam int BLK_ROWS = 84;
  localparam int NUM_BLK = 672;
  localparam int BUF_BANKS = 2;
  localparam logic [2:0] LAST_WCOL = 3'h7;
  localparam logic [5:0] LAST_WROW = 6'h29;
  localparam logic [6:0] HALF_ROW_BASE = 7'h2a;
  localparam logic [5:0] LAST_GRP = 6'h29;
  localparam logic [6:0] LAST_BIT_COL = 7'h7f;
  localparam logic [1:0] LAST_SUBSET = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Framing geometry.
  localparam logic [11:0] SUBFRAME_LAST = 12'he7f;
  localparam logic [5:0] SUBFRAME_CNT_LAST = 6'h2f;
  localparam logic [11:0] TRAIN_LEN = 12'h00b;
  localparam logic [6:0] FAW_LEN = 7'h16;
  localparam logic [6:0] FAW_RSV_LEN = 7'h60;

  ////////////////////////////////////////////////////////////////////////////
  // Overhead sequences and generators.
  localparam logic [9:0] PILOT_SEED_X = 10'h19e;
  localparam logic [9:0] PILOT_SEED_Y = 10'h0d0;
  localparam logic [14:0] RSV_SEED = 15'h7fff;
  // Each entry is {x_i, x_q, y_i, y_q}; a set bit means the positive point.
  localparam logic [0:10][3:0] TS_TAB = {
    4'h4, 4'hc, 4'h6, 4'hd, 4'h1, 4'hf, 4'h0, 4'h1, 4'he, 4'hb, 4'ha};
  localparam logic [0:21][3:0] FAW_TAB = {
    4'hb, 4'hd, 4'hc, 4'hd, 4'ha, 4'hb, 4'h2, 4'he, 4'h0, 4'h6, 4'h7,
    4'h9, 4'h1, 4'h3, 4'h4, 4'hf, 4'h0, 4'h9, 4'h6, 4'hc, 4'h2, 4'h5};

  ////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [2:0] {
    SLOT_DATA  = 3'b000,
    SLOT_PILOT = 3'b001,
    SLOT_TRAIN = 3'b010,
    SLOT_FAW   = 3'b011,
    SLOT_RSV   = 3'b100
  } fimf_slot_type;

  typedef struct packed {
    logic signed [2:0] xi;
    logic signed [2:0] xq;
    logic signed [2:0] yi;
    logic signed [2:0] yq;
  } fimf_sym_type;

  typedef struct packed {
    logic valid;
    logic [255:0] bits;
  } fimf_blk_type;

endpackage

// ### src/fimf_top.sv
// Interleaver, dual-polarization symbol mapper and super-frame builder.
// Assumes both encoders and the modulator run on clk; mode_16qam is static.
//
// Function
// - Permute each incoming 16x16 block before storing.
// - Source bit (14,15) lands at row 1, col 0.
// - Buffer holds 84 by 8 blocks, 172032 bits.
// - Encoder 0 to even rows, encoder 1 odd.
// - Four subsets of 21 block rows each.
// - Read 8-bit groups from subsets 0 to 3.
// - Finish 42 rounds per column, then next column.
// - Even bits feed H, odd bits feed V.
// - QPSK uses four bits per dual symbol.
// - QPSK label bit 0 gives -1, 1 gives +1.
// - 16-QAM uses eight bits per dual symbol.
// - Gray pairs 00,01,11,10 give -3,-1,1,3.
// - 48 sub-frames of 3712 symbols per super-frame.
// - Pilot every 32 symbols from sub-frame start.
// - Eleven training symbols open each sub-frame.
// - Alignment word only in the first sub-frame.
// - First sub-frame carries 74 randomized reserved symbols.
// - Later sub-frames carry only training, pilots and data.
// - Overhead uses QPSK or outer 16-QAM points.
// - Pilots from reseeded ten-bit PRBS per polarization.
// - Alignment word follows fixed per-index table.
`timescale 1ns/1ns
module fimf_top (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Modulation select, 1 for 16-QAM
  input wire logic mode_16qam,
  // Encoder block inputs, bit index is row*16+col
  input wire fimf_pkg::fimf_blk_type enc0_blk,
  output logic enc0_ready,
  input wire fimf_pkg::fimf_blk_type enc1_blk,
  output logic enc1_ready,
  // Symbol output toward the modulator
  output fimf_pkg::fimf_sym_type sym,
  output fimf_pkg::fimf_slot_type sym_kind,
  output logic sym_valid,
  input wire logic sym_ready,
  output logic sym_sub_start,
  output logic sym_super_start
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  function automatic logic [255:0] permute_blk(input logic [255:0] src);
    logic [3:0] sr;
    logic [3:0] sc;
    logic [255:0] dst;
    dst = '0;
    for (int r = 0; r < fimf_pkg::BLK_DIM; r++) begin
      for (int c = 0; c < fimf_pkg::BLK_DIM; c++) begin
        sr = 4'(c - 2 * r);
        sc = 4'(c - r);
        dst[r * fimf_pkg::BLK_DIM + c] = src[{sr, sc}];
      end
    end
    return dst;
  endfunction

  function automatic logic [7:0] pick8(input logic [255:0] w,
                                       input logic lower,
                                       input logic [3:0] cc);
    logic [7:0] b;
    b = '0;
    for (int k = 0; k < 8; k++) begin
      b[k] = w[{lower, 3'(k), cc}];
    end
    return b;
  endfunction

  function automatic logic signed [2:0] gray_amp(input logic b0,
                                                 input logic b1);
    logic signed [2:0] a;
    case ({b0, b1})
      2'b00: a = 3'h5;
      2'b01: a = 3'h7;
      2'b11: a = 3'h1;
      default: a = 3'h3;
    endcase
    return a;
  endfunction

  function automatic logic signed [2:0] sgn_amp(input logic b,
                                                input logic big);
    logic signed [2:0] a;
    if (b) begin
      a = big ? 3'h3 : 3'h1;
    end else begin
      a = big ? 3'h5 : 3'h7;
    end
    return a;
  endfunction

  function automatic fimf_pkg::fimf_sym_type pts(input logic [3:0] b,
                                                 input logic big);
    fimf_pkg::fimf_sym_type s;
    s.xi = sgn_amp(b[3], big);
    s.xq = sgn_amp(b[2], big);
    s.yi = sgn_amp(b[1], big);
    s.yq = sgn_amp(b[0], big);
    return s;
  endfunction

  // Two shifts per pilot symbol; the two leaving bits form I and Q.
  function automatic logic [9:0] lfsr2(input logic [9:0] s);
    logic [9:0] t;
    t = {s[8:0], s[9] ^ s[7] ^ s[3] ^ s[2]};
    return {t[8:0], t[9] ^ t[7] ^ t[3] ^ t[2]};
  endfunction

  function automatic logic [14:0] lfsr4(input logic [14:0] s);
    logic [14:0] t;
    t = s;
    for (int k = 0; k < 4; k++) begin
      t = {t[13:0], t[14] ^ t[13]};
    end
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Interleaver buffer, double banked so one fills while the other drains.

  logic [255:0] mem_q [fimf_pkg::BUF_BANKS][fimf_pkg::NUM_BLK];
  logic [255:0] enc_data [2];
  logic [1:0] enc_fire;
  logic [1:0] enc_rdy;
  logic [5:0] wrow_q [2];
  logic [2:0] wcol_q [2];
  logic [1:0] wdone_q;
  logic wb_q;
  logic rb_q;
  logic [1:0] full_q;
  logic bank_filled;
  logic rd_go;
  logic rd_last;

  assign enc_data[0] = enc0_blk.bits;
  assign enc_data[1] = enc1_blk.bits;
  assign bank_filled = &wdone_q;

  always_comb begin
    for (int e = 0; e < 2; e++) begin
      enc_rdy[e] = !full_q[wb_q] && !wdone_q[e];
    end
  end
  assign enc0_ready = enc_rdy[0];
  assign enc1_ready = enc_rdy[1];
  assign enc_fire = enc_rdy & {enc1_blk.valid, enc0_blk.valid};

  // Block row 2*row+e keeps the two encoders on alternate rows.
  always_ff @(posedge clk) begin
    for (int e = 0; e < 2; e++) begin
      if (enc_fire[e]) begin
        mem_q[wb_q][{wrow_q[e], 1'(e), wcol_q[e]}] <=
          permute_blk(enc_data[e]);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int e = 0; e < 2; e++) begin
        wrow_q[e] <= '0;
        wcol_q[e] <= '0;
      end
      wdone_q <= '0;
      wb_q <= 1'b0;
    end else begin
      for (int e = 0; e < 2; e++) begin
        if (enc_fire[e]) begin
          if (wcol_q[e] == fimf_pkg::LAST_WCOL) begin
            wcol_q[e] <= '0;
            if (wrow_q[e] == fimf_pkg::LAST_WROW) begin
              wrow_q[e] <= '0;
              wdone_q[e] <= 1'b1;
            end else begin
              wrow_q[e] <= wrow_q[e] + 6'h01;
            end
          end else begin
            wcol_q[e] <= wcol_q[e] + 3'h1;
          end
        end
      end
      if (bank_filled) begin
        wdone_q <= '0;
        wb_q <= ~wb_q;
      end
    end
  end

  // A bank is set full and drained full in different banks, so no race.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      full_q <= '0;
    end else begin
      if (rd_go && rd_last) begin
        full_q[rb_q] <= 1'b0;
      end
      if (bank_filled) begin
        full_q[wb_q] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Column-wise readout in 8-bit groups across the four subsets.

  logic [6:0] rcol_q;
  logic [5:0] rgrp_q;
  logic [1:0] rsub_q;
  logic [6:0] rblk_row;
  logic [7:0] byte_q;
  logic byte_v_q;
  logic half_q;
  logic pay_take;
  logic byte_done;

  assign rblk_row = (rsub_q[1] ? fimf_pkg::HALF_ROW_BASE : 7'h00)
                  + {6'h00, rsub_q[0]} + {rgrp_q[5:1], 1'b0};
  assign rd_last = (rcol_q == fimf_pkg::LAST_BIT_COL)
                && (rgrp_q == fimf_pkg::LAST_GRP)
                && (rsub_q == fimf_pkg::LAST_SUBSET);
  assign byte_done = pay_take && (mode_16qam || half_q);
  assign rd_go = full_q[rb_q] && (!byte_v_q || byte_done);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rcol_q <= '0;
      rgrp_q <= '0;
      rsub_q <= '0;
      rb_q <= 1'b0;
    end else if (rd_go) begin
      rsub_q <= rsub_q + 2'h1;
      if (rsub_q == fimf_pkg::LAST_SUBSET) begin
        if (rgrp_q == fimf_pkg::LAST_GRP) begin
          rgrp_q <= '0;
          rcol_q <= rcol_q + 7'h01;
        end else begin
          rgrp_q <= rgrp_q + 6'h01;
        end
      end
      if (rd_last) begin
        rb_q <= ~rb_q;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      byte_q <= '0;
      byte_v_q <= 1'b0;
      half_q <= 1'b0;
    end else begin
      if (rd_go) begin
        byte_q <= pick8(mem_q[rb_q][{rblk_row, rcol_q[6:4]}],
                        rgrp_q[0], rcol_q[3:0]);
        byte_v_q <= 1'b1;
      end else if (byte_done) begin
        byte_v_q <= 1'b0;
      end
      if (pay_take && !mode_16qam) begin
        half_q <= ~half_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Symbol mapping of payload bits.

  logic [3:0] nib;
  fimf_pkg::fimf_sym_type pay_sym;

  assign nib = half_q ? byte_q[7:4] : byte_q[3:0];

  // Even stream bits go to X (H), odd bits to Y (V).
  always_comb begin
    if (mode_16qam) begin
      pay_sym.xi = gray_amp(byte_q[0], byte_q[2]);
      pay_sym.xq = gray_amp(byte_q[4], byte_q[6]);
      pay_sym.yi = gray_amp(byte_q[1], byte_q[3]);
      pay_sym.yq = gray_amp(byte_q[5], byte_q[7]);
    end else begin
      pay_sym = pts({nib[0], nib[2], nib[1], nib[3]}, 1'b0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sub-frame and super-frame sequencing.

  logic [11:0] pos_q;
  logic [5:0] sub_q;
  logic [6:0] oh_q;
  logic [9:0] plx_q;
  logic [9:0] ply_q;
  logic [14:0] rsv_q;
  fimf_pkg::fimf_slot_type gen_kind;
  fimf_pkg::fimf_sym_type gen_sym;
  logic adv;
  logic sub_end;

  always_comb begin
    if (pos_q < fimf_pkg::TRAIN_LEN) begin
      gen_kind = fimf_pkg::SLOT_TRAIN;
    end else if (pos_q[4:0] == 5'h00) begin
      gen_kind = fimf_pkg::SLOT_PILOT;
    end else if (sub_q == 6'h00 && oh_q < fimf_pkg::FAW_LEN) begin
      gen_kind = fimf_pkg::SLOT_FAW;
    end else if (sub_q == 6'h00 && oh_q < fimf_pkg::FAW_RSV_LEN) begin
      gen_kind = fimf_pkg::SLOT_RSV;
    end else begin
      gen_kind = fimf_pkg::SLOT_DATA;
    end
  end

  always_comb begin
    case (gen_kind)
      fimf_pkg::SLOT_TRAIN: begin
        gen_sym = pts(fimf_pkg::TS_TAB[pos_q[3:0]], mode_16qam);
      end
      fimf_pkg::SLOT_PILOT: begin
        gen_sym = pts({plx_q[9:8], ply_q[9:8]}, mode_16qam);
      end
      fimf_pkg::SLOT_FAW: begin
        gen_sym = pts(fimf_pkg::FAW_TAB[oh_q[4:0]], mode_16qam);
      end
      fimf_pkg::SLOT_RSV: begin
        gen_sym = pts(rsv_q[3:0], mode_16qam);
      end
      default: begin
        gen_sym = pay_sym;
      end
    endcase
  end

  // Payload slots wait for interleaver data; overhead slots wait only for sym_ready.
  assign adv = (gen_kind != fimf_pkg::SLOT_DATA || byte_v_q)
            && (!sym_valid || sym_ready);
  assign pay_take = adv && gen_kind == fimf_pkg::SLOT_DATA;
  assign sub_end = pos_q == fimf_pkg::SUBFRAME_LAST;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_q <= '0;
      sub_q <= '0;
      oh_q <= '0;
    end else if (adv) begin
      if (sub_end) begin
        pos_q <= '0;
        oh_q <= '0;
        if (sub_q == fimf_pkg::SUBFRAME_CNT_LAST) begin
          sub_q <= '0;
        end else begin
          sub_q <= sub_q + 6'h01;
        end
      end else begin
        pos_q <= pos_q + 12'h001;
        if (gen_kind == fimf_pkg::SLOT_FAW ||
            gen_kind == fimf_pkg::SLOT_RSV) begin
          oh_q <= oh_q + 7'h01;
        end
      end
    end
  end

  // Position 0 advances the generator too, since training symbol 0 is
  // also the first pilot of the sub-frame.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      plx_q <= fimf_pkg::PILOT_SEED_X;
      ply_q <= fimf_pkg::PILOT_SEED_Y;
      rsv_q <= fimf_pkg::RSV_SEED;
    end else if (adv) begin
      if (sub_end) begin
        plx_q <= fimf_pkg::PILOT_SEED_X;
        ply_q <= fimf_pkg::PILOT_SEED_Y;
      end else if (pos_q[4:0] == 5'h00) begin
        plx_q <= lfsr2(plx_q);
        ply_q <= lfsr2(ply_q);
      end
      if (gen_kind == fimf_pkg::SLOT_RSV) begin
        rsv_q <= lfsr4(rsv_q);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered output stage.

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sym <= '0;
      sym_kind <= fimf_pkg::SLOT_DATA;
      sym_valid <= 1'b0;
      sym_sub_start <= 1'b0;
      sym_super_start <= 1'b0;
    end else if (adv) begin
      sym <= gen_sym;
      sym_kind <= gen_kind;
      sym_valid <= 1'b1;
      sym_sub_start <= pos_q == 12'h000;
      sym_super_start <= pos_q == 12'h000 && sub_q == 6'h00;
    end else if (sym_ready) begin
      sym_valid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  AST_PILOT_PERIOD: assert property (
    @(posedge clk) disable iff (!arst_n)
    adv && pos_q[4:0] == 5'h00 && pos_q != 12'h000
    |=> sym_valid && sym_kind == fimf_pkg::SLOT_PILOT)
    else $error("pilot missing at 32-symbol boundary");

  AST_TRAIN_START: assert property (
    @(posedge clk) disable iff (!arst_n)
    adv && pos_q == 12'h000
    |=> sym_kind == fimf_pkg::SLOT_TRAIN && sym_sub_start
        && sym == pts(fimf_pkg::TS_TAB[0], $past(mode_16qam)))
    else $error("sub-frame does not open with training symbol");

  AST_NO_FAW_LATER: assert property (
    @(posedge clk) disable iff (!arst_n)
    adv && sub_q != 6'h00
    |=> sym_kind != fimf_pkg::SLOT_FAW && sym_kind != fimf_pkg::SLOT_RSV)
    else $error("alignment or reserved symbol outside first sub-frame");

  AST_SUBFRAME_WRAP: assert property (
    @(posedge clk) disable iff (!arst_n)
    adv && sub_end
    |=> pos_q == 12'h000
        && sub_q == ($past(sub_q) == 6'h2f ? 6'h00 : $past(sub_q) + 6'h01))
    else $error("sub-frame length or count wrong");

  AST_OH_COUNT: assert property (
    @(posedge clk) disable iff (!arst_n)
    adv && sub_end && sub_q == 6'h00 |-> oh_q == 7'h60)
    else $error("first sub-frame overhead count not 96");

  AST_QPSK_AMP: assert property (
    @(posedge clk) disable iff (!arst_n)
    sym_valid && !mode_16qam
    |-> (sym.xi == 3'h1 || sym.xi == 3'h7)
        && (sym.yq == 3'h1 || sym.yq == 3'h7))
    else $error("QPSK amplitude not plus or minus one");

  AST_OUTER_POINTS: assert property (
    @(posedge clk) disable iff (!arst_n)
    sym_valid && mode_16qam && sym_kind != fimf_pkg::SLOT_DATA
    |-> (sym.xi == 3'h3 || sym.xi == 3'h5)
        && (sym.yq == 3'h3 || sym.yq == 3'h5))
    else $error("overhead symbol not on outer 16-QAM point");

  AST_FULL_STALL: assert property (
    @(posedge clk) disable iff (!arst_n)
    bank_filled |=> full_q[$past(wb_q)] && wb_q != $past(wb_q))
    else $error("filled bank not handed to readout");

  AST_COLUMN_STEP: assert property (
    @(posedge clk) disable iff (!arst_n)
    rd_go && rsub_q == 2'h3 && rgrp_q == 6'h29
    |=> rgrp_q == 6'h00 && rsub_q == 2'h0
        && rcol_q == $past(rcol_q) + 7'h01)
    else $error("readout column step wrong");

endmodule // fimf_top

// ### sim/fimf_far_end.sv
// Model of the two encoders and the modulator around the framing stage.
// Assumes clk and arst_n are shared with the stage; inputs change on edges.
`timescale 1ns/1ns
module fimf_far_end (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Encoder side
  output fimf_pkg::fimf_blk_type enc0_blk,
  input wire logic enc0_ready,
  output fimf_pkg::fimf_blk_type enc1_blk,
  input wire logic enc1_ready,
  // Modulator side
  output logic sym_ready,
  input wire logic stall_en,
  // Blocks accepted so far
  output int n_taken0,
  output int n_taken1
);

  ////////////////////////////////////////////////////////////////////////////
  // Encoder 0 sets a bit when its column modulo 4 is 0 or 1, encoder 1 the
  // opposite. Idle data shows the inverse so that a stale block never passes.
  logic [1:0] ph_q;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enc0_blk <= '{valid: 1'b0, bits: {64{4'hc}}};
      enc1_blk <= '{valid: 1'b0, bits: {64{4'h3}}};
      sym_ready <= 1'b0;
      ph_q <= 2'h0;
      n_taken0 <= 0;
      n_taken1 <= 0;
    end else begin
      enc0_blk <= '{valid: 1'b1, bits: {64{4'h3}}};
      enc1_blk <= '{valid: 1'b1, bits: {64{4'hc}}};
      ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
      // A slow modulator refuses one symbol in three.
      sym_ready <= !(stall_en && ph_q == 2'h1);
      n_taken0 <= n_taken0 + int'(enc0_blk.valid && enc0_ready);
      n_taken1 <= n_taken1 + int'(enc1_blk.valid && enc1_ready);
    end
  end

endmodule // fimf_far_end

// ### sim/tb_fec_interleave_map_framer.sv
// Self-checking bench for the interleave, map and framing stage.
// Assumes fimf_pkg and the far-end model are compiled first.
`timescale 1ns/1ns
module tb_fec_interleave_map_framer;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic mode_16qam = 1'b0;
  logic stall_en = 1'b0;
  fimf_pkg::fimf_blk_type enc0_blk;
  fimf_pkg::fimf_blk_type enc1_blk;
  logic enc0_ready;
  logic enc1_ready;
  logic sym_valid;
  logic sym_ready;
  logic sym_sub_start;
  logic sym_super_start;
  fimf_pkg::fimf_sym_type sym;
  fimf_pkg::fimf_slot_type sym_kind;
  int n_taken0;
  int n_taken1;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  int nd = 0;
  logic held = 1'b0;
  fimf_pkg::fimf_sym_type last;
  fimf_pkg::fimf_sym_type q_sym[$];
  logic [4:0] q_tag[$];

  always #10 clk = ~clk;

  fimf_top i_fimf_top (.clk(clk), .arst_n(arst_n), .mode_16qam(mode_16qam),
    .enc0_blk(enc0_blk), .enc0_ready(enc0_ready), .enc1_blk(enc1_blk),
    .enc1_ready(enc1_ready), .sym(sym), .sym_kind(sym_kind),
    .sym_valid(sym_valid), .sym_ready(sym_ready),
    .sym_sub_start(sym_sub_start), .sym_super_start(sym_super_start));

  fimf_far_end i_fimf_far_end (.clk(clk), .arst_n(arst_n),
    .enc0_blk(enc0_blk), .enc0_ready(enc0_ready), .enc1_blk(enc1_blk),
    .enc1_ready(enc1_ready), .sym_ready(sym_ready), .stall_en(stall_en),
    .n_taken0(n_taken0), .n_taken1(n_taken1));

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.
  task automatic chk(input string what, input logic [12:0] e,
                     input logic [12:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s: expected %h, seen %h", what, e, g);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  function automatic logic [2:0] amp(input logic b);
    return b ? (mode_16qam ? 3'h3 : 3'h1) : (mode_16qam ? 3'h5 : 3'h7);
  endfunction

  function automatic logic [2:0] gray(input logic a, input logic b);
    case ({a, b})
      2'b00: return 3'h5;
      2'b01: return 3'h7;
      2'b11: return 3'h1;
      default: return 3'h3;
    endcase
  endfunction

  function automatic logic [11:0] ovh(input logic [3:0] p);
    return {amp(p[3]), amp(p[2]), amp(p[1]), amp(p[0])};
  endfunction

  function automatic logic [3:0] pil(input int m);
    logic [9:0] x;
    logic [9:0] y;
    x = fimf_pkg::PILOT_SEED_X;
    y = fimf_pkg::PILOT_SEED_Y;
    repeat (2 * m) begin
      x = {x[8:0], x[9] ^ x[7] ^ x[3] ^ x[2]};
      y = {y[8:0], y[9] ^ y[7] ^ y[3] ^ y[2]};
    end
    return {x[9], x[8], y[9], y[8]};
  endfunction

  // Byte n comes from subset n%4 and bit column n/168; the far-end pattern
  // after permutation depends only on column minus row modulo 4.
  function automatic logic [11:0] dat(input int d);
    int n;
    logic [7:0] b;
    n = mode_16qam ? d : d / 2;
    for (int k = 0; k < 8; k++)
      b[k] = ((n / 168 - k) & 3) < 2;
    if (n % 2 == 1)
      b = ~b;
    if (mode_16qam)
      return {gray(b[0], b[2]), gray(b[4], b[6]), gray(b[1], b[3]),
              gray(b[5], b[7])};
    if (d % 2 == 1)
      b = b >> 4;
    return {amp(b[0]), amp(b[2]), amp(b[1]), amp(b[3])};
  endfunction

  task automatic do_reset(input logic qam, input logic slow);
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    mode_16qam <= qam;
    stall_en <= slow;
    nd = 0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
  endtask

  task automatic wait_syms(input int n);
    while (q_sym.size() < n)
      @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Monitor of consumed symbols, hold check and hang guard.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      $display("wrong value cycle limit: expected done, seen running");
      tally_and_finish();
    end
    if (held && arst_n)
      chk("held symbol", {1'b1, last}, {sym_valid, sym});
    held = arst_n && sym_valid && !sym_ready;
    last = sym;
    if (!arst_n) begin
      q_sym.delete();
      q_tag.delete();
    end else if (sym_valid && sym_ready) begin
      q_sym.push_back(sym);
      q_tag.push_back({sym_super_start, sym_sub_start, sym_kind});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Walks one sub-frame of the recorded stream against the frame layout.
  task automatic check_frame(input int base, input int len, input bit first);
    int nf;
    int nr;
    int np;
    int same;
    fimf_pkg::fimf_slot_type ek;
    fimf_pkg::fimf_sym_type s;
    fimf_pkg::fimf_sym_type r0;
    nf = 0;
    nr = 0;
    np = 0;
    same = 0;
    for (int p = 0; p < len; p++) begin
      s = q_sym[base + p];
      if (p < 11)
        ek = fimf_pkg::SLOT_TRAIN;
      else if (p % 32 == 0)
        ek = fimf_pkg::SLOT_PILOT;
      else if (first && nf < 22)
        ek = fimf_pkg::SLOT_FAW;
      else if (first && nr < 74)
        ek = fimf_pkg::SLOT_RSV;
      else
        ek = fimf_pkg::SLOT_DATA;
      chk("kind", {first && p == 0, p == 0, ek}, q_tag[base + p]);
      if (p == 0)
        chk("first pilot", ovh(pil(0)), s);
      case (ek)
        fimf_pkg::SLOT_TRAIN: chk("training", ovh(fimf_pkg::TS_TAB[p]), s);
        fimf_pkg::SLOT_PILOT: begin
          chk("pilot", ovh(pil(p / 32)), s);
          np++;
        end
        fimf_pkg::SLOT_FAW: begin
          chk("alignment", ovh(fimf_pkg::FAW_TAB[nf]), s);
          nf++;
        end
        fimf_pkg::SLOT_RSV: begin
          if (nr == 0)
            r0 = s;
          same += int'(s === r0);
          nr++;
        end
        default: begin
          if (nd < 400)
            chk("data", dat(nd), s);
          nd++;
        end
      endcase
    end
    if (len == 3712) begin
      chk("alignment count", 13'd22, nf);
      chk("reserved count", 13'd74, nr);
      chk("reserved spread", 13'd1, same < 20);
      chk("pilot count", 13'd115, np);
      chk("data count", 13'd3490, nd);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  // QPSK with a slow modulator: whole first sub-frame and start of the next.
  task automatic sc_qpsk_frames;
    do_reset(1'b0, 1'b1);
    wait_syms(3712 + 200);
    check_frame(0, 3712, 1'b1);
    check_frame(3712, 200, 1'b0);
    // Both banks stay full while the first is still being read out.
    chk("encoder 0 blocks", 13'd672, n_taken0);
    chk("encoder 1 blocks", 13'd672, n_taken1);
    chk("encoder 0 ready", 13'd0, enc0_ready);
  endtask

  // 16-QAM after a reset in mid-run, fast modulator, three bit columns checked.
  task automatic sc_qam_frame;
    do_reset(1'b1, 1'b0);
    wait_syms(700);
    check_frame(0, 700, 1'b1);
  endtask

  initial begin
    sc_qpsk_frames();
    sc_qam_frame();
    tally_and_finish();
  end

endmodule // tb_fec_interleave_map_framer
